// ---- rtl/uesc_pkg.sv ----
// constants and types for the usb endpoint status and control block
package uesc_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int          AW           = 16;
    localparam logic [15:0] OFS_STATUS   = 16'h0000;
    localparam logic [15:0] OFS_FLAGS    = 16'h0004;
    localparam logic [15:0] OFS_ADDR     = 16'h0008;
    localparam logic [15:0] OFS_FRM_LO   = 16'h000C;
    localparam logic [15:0] OFS_FRM_HI   = 16'h0010;
    localparam logic [9:0]  OFS_EP_PAGE  = 10'h004;
    localparam logic [3:0]  OFS_RAM_PAGE = 4'h1;
    // ****************************************
    // field layouts
    // ****************************************
    localparam int NUM_EP     = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int CTL_W      = 5;
    localparam int CTL_STALL  = 0;
    localparam int CTL_IN     = 1;
    localparam int CTL_OUT    = 2;
    localparam int CTL_CONDIS = 3;
    localparam int CTL_HSHK   = 4;
    localparam int ST_ODD     = 1;
    localparam int ST_DIR     = 2;
    localparam int ST_EP_LO   = 3;
    localparam int FLG_XFER   = 0;
    localparam int FLG_BRST   = 1;
    localparam int FRM_W      = 11;
    localparam int ADDR_W     = 7;
    localparam int RAM_BYTES  = 1024;
    // ****************************************
    // usb ram window and reset values
    // ****************************************
    localparam logic [10:0]       RAM_FIRST  = 11'h400;
    localparam logic [10:0]       RAM_LAST   = 11'h7FF;
    localparam logic [10:0]       DESC_LAST  = 11'h4FF;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 7'h00;
    localparam logic [CTL_W-1:0]  CTL_RST    = 5'h00;
    localparam logic [2:0]        CNT_FULL   = 3'h4;
    localparam logic [1:0]        RESP_OKAY  = 2'h0;
    localparam logic [1:0]        RESP_SLV   = 2'h2;
    // ****************************************
    // token kinds and answers to the engine
    // ****************************************
    typedef enum logic [2:0] {
        PID_OUT   = 3'h1,
        PID_IN    = 3'h2,
        PID_SETUP = 3'h4
    } uesc_pid_t;
    typedef enum logic [4:0] {
        RSP_IGNORE = 5'h01,
        RSP_NAK    = 5'h02,
        RSP_STALL  = 5'h04,
        RSP_ACCEPT = 5'h08,
        RSP_NOHS   = 5'h10
    } uesc_rsp_t;
endpackage

// ---- rtl/uesc_top.sv ----
// usb endpoint status fifo, endpoint control, address, frame number and usb ram
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module uesc_top
    import uesc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // axi4-lite write channels
    input  wire logic [uesc_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read channels
    input  wire logic [uesc_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // token decode from the serial interface engine
    input  wire logic                   tok_valid,
    input  wire uesc_pkg::uesc_pid_t    tok_pid,
    input  wire logic [3:0]             tok_ep,
    input  wire logic [uesc_pkg::ADDR_W-1:0] tok_addr,
    output uesc_pkg::uesc_rsp_t         tok_rsp,
    // engine events
    input  wire logic                   xfer_done,
    input  wire logic [3:0]             xfer_ep,
    input  wire logic                   xfer_in,
    input  wire logic                   xfer_odd,
    input  wire logic                   stall_issued,
    input  wire logic [3:0]             stall_ep,
    input  wire logic                   sof_valid,
    input  wire logic [uesc_pkg::FRM_W-1:0] sof_frame,
    input  wire logic                   bus_reset,
    // engine port of the usb ram
    input  wire logic [10:0]            eng_ram_addr,
    input  wire logic                   eng_ram_we,
    input  wire logic [7:0]             eng_ram_wdata,
    output logic [7:0]                  eng_ram_rdata
);
    import uesc_pkg::*;

    // ****************************************
    // address decode helpers
    // ****************************************
    function automatic logic is_ep(input logic [AW-1:0] a);
        is_ep = (a[AW-1:6] == OFS_EP_PAGE);
    endfunction
    function automatic logic is_ram(input logic [AW-1:0] a);
        is_ram = (a[AW-1:12] == OFS_RAM_PAGE);
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0]        fifo_r [FIFO_DEPTH];
    logic [1:0]        head_r;
    logic [2:0]        count_r;
    logic [2:0]        count_nxt;
    logic [CTL_W-1:0]  ep_ctl_r [NUM_EP];
    logic [ADDR_W-1:0] addr_r;
    logic [FRM_W-1:0]  frame_r;
    logic              brst_flag_r;
    logic [7:0]        ram_r [RAM_BYTES];
    logic              aw_got_r;
    logic              w_got_r;
    logic [AW-1:0]     aw_addr_r;
    logic [7:0]        w_byte_r;
    logic              w_lane0_r;

    // ****************************************
    // axi write path
    // ****************************************
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_wr    = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire wr_lane  = do_wr & w_lane0_r;
    wire wr_flags = wr_lane & (aw_addr_r == OFS_FLAGS);
    wire wr_addr  = wr_lane & (aw_addr_r == OFS_ADDR);
    wire wr_ep    = wr_lane & is_ep(aw_addr_r);
    wire wr_ram   = wr_lane & is_ram(aw_addr_r);
    wire wr_known = (aw_addr_r[1:0] == 2'h0) & (is_ep(aw_addr_r) | is_ram(aw_addr_r)
                    | aw_addr_r == OFS_STATUS | aw_addr_r == OFS_FLAGS | aw_addr_r == OFS_ADDR
                    | aw_addr_r == OFS_FRM_LO | aw_addr_r == OFS_FRM_HI);
    wire [3:0] wr_ep_idx  = aw_addr_r[5:2];
    wire [9:0] wr_ram_idx = aw_addr_r[11:2];

    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;

    // both channels may arrive in either order; commit once both are held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            aw_addr_r    <= '0;
            w_byte_r     <= 8'h00;
            w_lane0_r    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_got_r   <= 1'b1;
                w_byte_r  <= s_axi_wdata[7:0];
                w_lane0_r <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLV;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // status fifo
    // ****************************************
    wire       fifo_full  = (count_r == CNT_FULL);
    wire       xfer_flag  = (count_r != 3'h0);
    wire       fifo_push  = xfer_done & ~fifo_full;
    wire       fifo_pop   = wr_flags & w_byte_r[FLG_XFER] & xfer_flag;
    wire [1:0] tail       = head_r + count_r[1:0];
    wire [7:0] status_ent = {1'b0, xfer_ep, xfer_in, xfer_odd, 1'b0};
    wire [7:0] status_win = fifo_r[head_r];

    // push and pop in one cycle leave the count alone, so no completion is lost
    always_comb begin
        count_nxt = count_r;
        if (fifo_push && !fifo_pop) begin
            count_nxt = count_r + 3'h1;
        end else if (fifo_pop && !fifo_push) begin
            count_nxt = count_r - 3'h1;
        end
    end

    // fifo bookkeeping; bus reset empties it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_r  <= 2'h0;
            count_r <= 3'h0;
        end else if (bus_reset) begin
            head_r  <= 2'h0;
            count_r <= 3'h0;
        end else begin
            count_r <= count_nxt;
            if (fifo_pop) begin
                head_r <= head_r + 2'h1;
            end
        end
    end

    // entries hold data only; validity lives in the count
    always_ff @(posedge clk) begin
        if (fifo_push) begin
            fifo_r[tail] <= status_ent;
        end
    end

    // ****************************************
    // endpoint control, address, frame
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_EP; i++) begin
                ep_ctl_r[i] <= CTL_RST;
            end
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (wr_ep && wr_ep_idx == 4'(i)) begin
                    ep_ctl_r[i] <= w_byte_r[CTL_W-1:0];
                end
                // an issued stall beats a firmware clear in the same cycle
                if (stall_issued && stall_ep == 4'(i)) begin
                    ep_ctl_r[i][CTL_STALL] <= 1'b1;
                end
            end
        end
    end

    // address and frame; frame takes no software writes at all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r      <= ADDR_RST;
            frame_r     <= '0;
            brst_flag_r <= 1'b0;
        end else begin
            if (bus_reset) begin
                addr_r <= ADDR_RST;
            end else if (wr_addr) begin
                addr_r <= w_byte_r[ADDR_W-1:0];
            end
            if (sof_valid) begin
                frame_r <= sof_frame;
            end
            if (bus_reset) begin
                brst_flag_r <= 1'b1;
            end else if (wr_flags && w_byte_r[FLG_BRST]) begin
                brst_flag_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // token answer
    // ****************************************
    wire [CTL_W-1:0] tok_ctl = ep_ctl_r[tok_ep];
    wire addr_hit = (tok_addr == addr_r);
    wire dir_ok   = (tok_pid == PID_OUT)   ? tok_ctl[CTL_OUT] :
                    (tok_pid == PID_IN)    ? tok_ctl[CTL_IN] :
                    (tok_pid == PID_SETUP) ? (tok_ctl[CTL_OUT] & tok_ctl[CTL_IN]
                                              & ~tok_ctl[CTL_CONDIS]) : 1'b0;
    wire tok_live = tok_valid & addr_hit & dir_ok;
    wire hshk     = tok_ctl[CTL_HSHK];

    // stall only counts on a live, enabled endpoint; a full fifo can only be nak-ed
    // when handshakes are on, otherwise the packet is dropped
    assign tok_rsp = !tok_live           ? RSP_IGNORE :
                     fifo_full && hshk   ? RSP_NAK :
                     fifo_full           ? RSP_IGNORE :
                     tok_ctl[CTL_STALL]  ? RSP_STALL :
                     hshk                ? RSP_ACCEPT : RSP_NOHS;

    // ****************************************
    // usb ram, two ports
    // ****************************************
    wire       eng_hit = (eng_ram_addr >= RAM_FIRST) & (eng_ram_addr <= RAM_LAST);
    wire [9:0] eng_idx = eng_ram_addr[9:0];

    // no ownership interlock: the owner bit in ram is honoured by both parties,
    // and descriptors at the low 256 bytes are just bytes to this store
    always_ff @(posedge clk) begin
        if (wr_ram) begin
            ram_r[wr_ram_idx] <= w_byte_r;
        end
        if (eng_ram_we && eng_hit) begin
            ram_r[eng_idx] <= eng_ram_wdata;
        end
    end

    // engine read data registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng_ram_rdata <= 8'h00;
        end else begin
            eng_ram_rdata <= eng_hit ? ram_r[eng_idx] : 8'h00;
        end
    end

    // ****************************************
    // axi read path
    // ****************************************
    wire [AW-1:0] ra      = s_axi_araddr;
    wire          ra_al   = (ra[1:0] == 2'h0);
    wire          ra_ep   = ra_al & is_ep(ra);
    wire          ra_ram  = ra_al & is_ram(ra);
    wire [7:0]    rd_byte = (ra == OFS_STATUS) ? status_win :
                            (ra == OFS_FLAGS)  ? {6'h00, brst_flag_r, xfer_flag} :
                            (ra == OFS_ADDR)   ? {1'b0, addr_r} :
                            (ra == OFS_FRM_LO) ? frame_r[7:0] :
                            (ra == OFS_FRM_HI) ? {5'h00, frame_r[FRM_W-1:8]} :
                            ra_ep              ? {3'h0, ep_ctl_r[ra[5:2]]} :
                            ra_ram             ? ram_r[ra[11:2]] : 8'h00;
    wire          rd_ok   = ra_ep | ra_ram | ra == OFS_STATUS | ra == OFS_FLAGS
                            | ra == OFS_ADDR | ra == OFS_FRM_LO | ra == OFS_FRM_HI;

    assign s_axi_arready = ~s_axi_rvalid;

    // one read in flight; answer registered on the same edge that takes the address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLV;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_full_gives_nak: assert property (tok_live && fifo_full && hshk |-> tok_rsp == RSP_NAK)
        else $error("full status fifo did not nak");
    a_pop_refires: assert property (fifo_pop && count_r > 3'h1 && !bus_reset |=> xfer_flag)
        else $error("complete flag not re-raised");
    a_pop_drains: assert property (fifo_pop && count_r == 3'h1 && !fifo_push && !bus_reset |=> !xfer_flag)
        else $error("complete flag stayed set on empty fifo");
    a_push_queues: assert property (fifo_push && xfer_flag && !fifo_pop && !bus_reset
                                   |=> count_r == $past(count_r) + 3'h1)
        else $error("pending completion overwrote status");
    a_status_spare: assert property (xfer_flag |-> !status_win[7] && !status_win[0])
        else $error("spare status bits not zero");
    a_stall_sets: assert property (stall_issued |=> ep_ctl_r[$past(stall_ep)][CTL_STALL])
        else $error("stall bit not set");
    a_addr_cleared: assert property (bus_reset |=> addr_r == ADDR_RST)
        else $error("bus address not cleared");
    a_frame_stored: assert property (sof_valid |=> frame_r == $past(sof_frame))
        else $error("frame number not captured");
    a_setup_blocked: assert property (tok_valid && tok_pid == PID_SETUP && tok_ctl[CTL_CONDIS]
                                     |-> tok_rsp == RSP_IGNORE)
        else $error("setup accepted with control disabled");
    a_reset_empties: assert property (bus_reset |=> !xfer_flag && head_r == 2'h0)
        else $error("status fifo not emptied");

    c_fifo_fills: cover property (fifo_push && count_r == 3'h3);
    c_push_pop: cover property (fifo_push && fifo_pop);
    c_stall_answer: cover property (tok_rsp == RSP_STALL);
    c_nak_answer: cover property (tok_rsp == RSP_NAK);
endmodule

// ---- test/uesc_host_model.sv ----
// stand-in for the usb host and engine side: tokens, events and the engine ram port
`timescale 1ns/100ps
module uesc_host_model
    import uesc_pkg::*;
(
    // clock
    input  wire logic                clk,
    // token link
    output logic                     tok_valid,
    output uesc_pkg::uesc_pid_t      tok_pid,
    output logic [3:0]               tok_ep,
    output logic [6:0]               tok_addr,
    input  wire uesc_pkg::uesc_rsp_t tok_rsp,
    // engine events
    output logic                     xfer_done,
    output logic [3:0]               xfer_ep,
    output logic                     xfer_in,
    output logic                     xfer_odd,
    output logic                     stall_issued,
    output logic [3:0]               stall_ep,
    output logic                     sof_valid,
    output logic [10:0]              sof_frame,
    output logic                     bus_reset,
    // engine ram port
    output logic [10:0]              eng_ram_addr,
    output logic                     eng_ram_we,
    output logic [7:0]               eng_ram_wdata,
    input  wire logic [7:0]          eng_ram_rdata
);
    // ****
    // idle levels, then one task per kind of traffic
    // ****
    initial begin
        {tok_valid, tok_ep, tok_addr, xfer_done, xfer_ep, xfer_in, xfer_odd} = '0;
        {stall_issued, stall_ep, sof_valid, sof_frame, bus_reset} = '0;
        {eng_ram_addr, eng_ram_we, eng_ram_wdata} = '0;
        tok_pid = PID_OUT;
    end
    // answer taken at the edge ending the token; payload inverted after release
    task automatic tok(input uesc_pid_t p, input logic [3:0] e, input logic [6:0] a, output uesc_rsp_t r);
        @(posedge clk);
        tok_valid <= 1'b1;
        tok_pid <= p;
        tok_ep <= e;
        tok_addr <= a;
        @(posedge clk);
        r = tok_rsp;
        tok_valid <= 1'b0;
        tok_ep <= ~e;
        tok_addr <= ~a;
    endtask
    // one-cycle event: 0 done, 1 stall, 2 frame start, 3 bus reset
    task automatic ev(input int k, input logic [10:0] v);
        @(posedge clk);
        xfer_done <= (k == 0);
        stall_issued <= (k == 1);
        sof_valid <= (k == 2);
        bus_reset <= (k == 3);
        {xfer_odd, xfer_in, xfer_ep} <= v[5:0];
        stall_ep <= v[3:0];
        sof_frame <= v;
        @(posedge clk);
        {xfer_done, stall_issued, sof_valid, bus_reset} <= 4'h0;
        sof_frame <= ~v;
    endtask
    // ram byte access; read data lands one cycle after the address
    task automatic ram(input logic [10:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        eng_ram_addr <= a;
        eng_ram_we <= w;
        eng_ram_wdata <= d;
        @(posedge clk);
        eng_ram_we <= 1'b0;
        @(posedge clk);
        q = eng_ram_rdata;
        eng_ram_wdata <= ~d;
    endtask
endmodule

// ---- test/test_usb_endpoint_status_control.sv ----
// self-checking bench for the usb endpoint status and control block
`timescale 1ns/100ps
module test_usb_endpoint_status_control;
    import uesc_pkg::*;
    // ****
    // signals
    // ****
    logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tok_valid;
    logic        xfer_done, xfer_in, xfer_odd, stall_issued, sof_valid, bus_reset, eng_ram_we;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, tok_ep, xfer_ep, stall_ep;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [6:0]  tok_addr;
    logic [10:0] sof_frame, eng_ram_addr;
    logic [7:0]  eng_ram_wdata, eng_ram_rdata, rd;
    uesc_pid_t   tok_pid;
    uesc_rsp_t   tok_rsp, rsp;
    int          fail_count, n_checks;
    uesc_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tok_valid, .tok_pid, .tok_ep,
        .tok_addr, .tok_rsp, .xfer_done, .xfer_ep, .xfer_in, .xfer_odd, .stall_issued, .stall_ep, .sof_valid,
        .sof_frame, .bus_reset, .eng_ram_addr, .eng_ram_we, .eng_ram_wdata, .eng_ram_rdata);
    uesc_host_model host (.clk, .tok_valid, .tok_pid, .tok_ep, .tok_addr, .tok_rsp, .xfer_done, .xfer_ep,
        .xfer_in, .xfer_odd, .stall_issued, .stall_ep, .sof_valid, .sof_frame, .bus_reset, .eng_ram_addr,
        .eng_ram_we, .eng_ram_wdata, .eng_ram_rdata);
    // ****
    // bus cycles and compares
    // ****
    // write and read hold each channel until its own handshake edge
    task automatic axw(input logic [15:0] a, input logic [7:0] d);
        logic ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        // no cycle count assumed; only the watchdog ends a hung wait
        while (!ok) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask
    task automatic axr(input logic [15:0] a);
        logic ok = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!ok) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata[7:0];
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rsp(input uesc_rsp_t got, input uesc_rsp_t exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t token answer %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        axr(a);
        chk(rd, e);
        chk({6'h00, rs}, {6'h00, RESP_OKAY});
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rchk(OFS_ADDR, 8'h00);
        rchk(OFS_FLAGS, 8'h00);
        rchk(16'h0114, 8'h00);
        axr(16'h0020);
        chk({6'h00, rs}, {6'h00, RESP_SLV});
        axw(16'h0020, 8'h00);
        chk({6'h00, rs}, {6'h00, RESP_SLV});
        $display("reset test done");
    endtask
    // one endpoint walked through control settings; stall wins over handshake
    task automatic t_ctl();
        logic [7:0] ctl [8] = '{8'h16, 8'h12, 8'h12, 8'h1E, 8'h16, 8'h06, 8'h17, 8'h01};
        uesc_pid_t  pid [8] = '{PID_OUT, PID_OUT, PID_IN, PID_SETUP, PID_SETUP, PID_OUT, PID_IN, PID_OUT};
        uesc_rsp_t  exp [8] = '{RSP_ACCEPT, RSP_IGNORE, RSP_ACCEPT, RSP_IGNORE,
                                RSP_ACCEPT, RSP_NOHS, RSP_STALL, RSP_IGNORE};
        axw(16'h0100, 8'h16);
        axw(OFS_ADDR, 8'h15);
        for (int i = 0; i < 8; i++) begin
            axw(16'h010C, ctl[i]);
            host.tok(pid[i], 4'h3, 7'h15, rsp);
            chk_rsp(rsp, exp[i]);
        end
        host.tok(PID_OUT, 4'h0, 7'h14, rsp);
        chk_rsp(rsp, RSP_IGNORE);
        axw(16'h010C, 8'h16);
        host.ev(1, 11'h003);
        rchk(16'h010C, 8'h17);
        axw(16'h010C, 8'hFF);
        rchk(16'h010C, 8'h1F);
        $display("control test done");
    endtask
    // five completions against four entries: the last is dropped
    task automatic t_fifo();
        logic [5:0] ent [5] = '{6'h11, 6'h22, 6'h3F, 6'h00, 6'h19};
        axw(16'h0108, 8'h16);
        for (int i = 0; i < 5; i++) host.ev(0, {5'h00, ent[i]});
        host.tok(PID_OUT, 4'h2, 7'h15, rsp);
        chk_rsp(rsp, RSP_NAK);
        for (int i = 0; i < 4; i++) begin
            rchk(OFS_FLAGS, 8'h01);
            rchk(OFS_STATUS, {1'b0, ent[i][3:0], ent[i][4], ent[i][5], 1'b0});
            axw(OFS_FLAGS, 8'h01);
        end
        rchk(OFS_FLAGS, 8'h00);
        host.tok(PID_OUT, 4'h2, 7'h15, rsp);
        chk_rsp(rsp, RSP_ACCEPT);
        host.ev(0, 11'h005);
        host.ev(3, 11'h000);
        rchk(OFS_ADDR, 8'h00);
        rchk(OFS_FLAGS, 8'h02);
        axw(OFS_FLAGS, 8'h02);
        rchk(OFS_FLAGS, 8'h00);
        $display("fifo test done");
    endtask
    task automatic t_frame();
        host.ev(2, 11'h5A3);
        rchk(OFS_FRM_LO, 8'hA3);
        rchk(OFS_FRM_HI, 8'h05);
        axw(OFS_FRM_LO, 8'h00);
        axw(OFS_FRM_HI, 8'h07);
        chk({6'h00, rs}, {6'h00, RESP_OKAY});
        rchk(OFS_FRM_LO, 8'hA3);
        rchk(OFS_FRM_HI, 8'h05);
        $display("frame test done");
    endtask
    // core and engine take turns on a buffer, never at once
    task automatic t_ram();
        axw(16'h148C, 8'h5C);
        host.ram(11'h523, 1'b0, 8'h00, rd);
        chk(rd, 8'h5C);
        host.ram(11'h400, 1'b1, 8'hA7, rd);
        rchk(16'h1000, 8'hA7);
        host.ram(11'h7FF, 1'b1, 8'h3C, rd);
        rchk(16'h1FFC, 8'h3C);
        // below the window: no store, reads zero, must not alias onto 7FFh
        host.ram(11'h3FF, 1'b1, 8'h11, rd);
        chk(rd, 8'h00);
        rchk(16'h1FFC, 8'h3C);
        $display("ram test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // clock, reset, main sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctl();
        t_fifo();
        t_frame();
        t_ram();
        close_out();
    end
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
